// file: shared/itm_pkg.sv
// package: constants and types of the interval timer counter channel
package itm_pkg;
   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   localparam logic [1:0]  ADDR_CTL   = 2'h3;
   localparam logic [1:0]  SC_RDBACK  = 2'h3;
   localparam logic [1:0]  RW_LATCH   = 2'h0;
   localparam logic [1:0]  RW_LSB     = 2'h1;
   localparam logic [1:0]  RW_MSB     = 2'h2;
   localparam logic [1:0]  RW_BOTH    = 2'h3;
   localparam int          RB_NO_CNT  = 5;
   localparam int          RB_NO_ST   = 4;
   localparam int          RB_SEL_LO  = 1;
   // ----------------------------------------------------------------
   // modes, reset values, counts
   // ----------------------------------------------------------------
   localparam logic [2:0]  MODE_0     = 3'h0;
   localparam logic [2:0]  MODE_1     = 3'h1;
   localparam logic [2:0]  MODE_2     = 3'h2;
   localparam logic [2:0]  MODE_3     = 3'h3;
   localparam logic [2:0]  MODE_4     = 3'h4;
   localparam logic [2:0]  MODE_5     = 3'h5;
   localparam logic [1:0]  RST_FMT    = 2'h1;
   localparam logic [2:0]  RST_MODE   = 3'h0;
   localparam logic [15:0] RST_CNT    = 16'h0000;
   localparam logic [15:0] CNT_ONE    = 16'h0001;
   localparam logic [15:0] CNT_TWO    = 16'h0002;
   localparam logic [1:0]  STEP_ONE   = 2'h1;
   localparam logic [1:0]  STEP_TWO   = 2'h2;
   localparam int          SYNC_W     = 15;
   localparam logic [14:0] SYNC_RST   = 15'h7000;
   localparam logic [1:0]  RST_SYNC   = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } itm_run_t;
endpackage : itm_pkg

// file: shared/itm_rd_if.sv
// interface: count and status readout path between channel core and readout latch
`timescale 1ns/1ps
interface itm_rd_if;
   logic [15:0] ce_val;
   logic [7:0]  status;
   logic [1:0]  fmt;
   logic        latch_cnt;
   logic        latch_st;
   logic        ctl_wr;
   logic        rd_done;
   logic [7:0]  rd_byte;

   modport core (output ce_val, status, fmt, latch_cnt, latch_st, ctl_wr, rd_done,
                 input rd_byte);
   modport rdo  (input ce_val, status, fmt, latch_cnt, latch_st, ctl_wr, rd_done,
                 output rd_byte);
endinterface : itm_rd_if

// file: src/itm_pin_sync.sv
// module: two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module itm_pin_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] din_i,
   output logic      [WIDTH-1:0] dout_o
);
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      // first stage feeds only the second stage
      always_ff @(posedge clk_i or negedge rst_n_i) begin
         if (!rst_n_i) begin
            meta_q <= RST_VAL[i];
            sync_q <= RST_VAL[i];
         end else begin
            meta_q <= din_i[i];
            sync_q <= meta_q;
         end
      end
      assign dout_o[i] = sync_q;
   end
endmodule : itm_pin_sync

// file: src/itm_readout.sv
// module: read latch, status latch and read byte sequencing of one counter
`timescale 1ns/1ps
module itm_readout
   import itm_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   itm_rd_if.rdo     rd
);
   logic [15:0] latch_q, latch_d;
   logic [7:0]  st_q, st_d;
   logic        cnt_lat_q, cnt_lat_d;
   logic        st_lat_q, st_lat_d;
   logic        rhi_q, rhi_d;
   logic [15:0] src;

   // ----------------------------------------------------------------
   // latch state
   // ----------------------------------------------------------------
   always_comb begin
      latch_d   = latch_q;
      st_d      = st_q;
      cnt_lat_d = cnt_lat_q;
      st_lat_d  = st_lat_q;
      rhi_d     = rhi_q;
      if (rd.ctl_wr) begin
         cnt_lat_d = 1'b0;
         st_lat_d  = 1'b0;
         rhi_d     = 1'b0;
      end else begin
         if (rd.rd_done) begin
            if (st_lat_q) begin
               st_lat_d = 1'b0;
            end else if (rd.fmt == RW_BOTH && !rhi_q) begin
               rhi_d = 1'b1;
            end else begin
               rhi_d     = 1'b0;
               cnt_lat_d = 1'b0;
            end
         end
         // a second latch before the read is dropped
         if (rd.latch_cnt && !cnt_lat_d) begin
            latch_d   = rd.ce_val;
            cnt_lat_d = 1'b1;
         end
         if (rd.latch_st && !st_lat_d) begin
            st_d     = rd.status;
            st_lat_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         latch_q   <= RST_CNT;
         st_q      <= '0;
         cnt_lat_q <= 1'b0;
         st_lat_q  <= 1'b0;
         rhi_q     <= 1'b0;
      end else begin
         latch_q   <= latch_d;
         st_q      <= st_d;
         cnt_lat_q <= cnt_lat_d;
         st_lat_q  <= st_lat_d;
         rhi_q     <= rhi_d;
      end
   end

   // ----------------------------------------------------------------
   // read byte select
   // ----------------------------------------------------------------
   // unlatched reads see the live count; only safe with counting halted
   assign src = cnt_lat_q ? latch_q : rd.ce_val;
   always_comb begin
      if (st_lat_q) begin
         rd.rd_byte = st_q;
      end else if (rd.fmt == RW_MSB || (rd.fmt == RW_BOTH && rhi_q)) begin
         rd.rd_byte = src[15:8];
      end else begin
         rd.rd_byte = src[7:0];
      end
   end

   latch_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      rd.latch_cnt && cnt_lat_q && !rd.ctl_wr && !rd.rd_done |=> latch_q == $past(latch_q))
      else $error("count latch changed while already latched");
   status_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      st_lat_q && cnt_lat_q |-> rd.rd_byte == st_q)
      else $error("status not returned first");
endmodule : itm_readout

// file: src/itm_timer.sv
// module: one counter channel of a programmable 16-bit down-counting interval timer
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
module itm_timer
   import itm_pkg::*;
#(
   parameter logic [1:0] CHAN = 2'h0
) (
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   input  wire logic       cs_n_i,
   input  wire logic       rd_n_i,
   input  wire logic       wr_n_i,
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] data_i,
   output logic      [7:0] data_o,
   output logic            data_oe_o,
   input  wire logic       cnt_clk_i,
   input  wire logic       gate_i,
   output logic            cnt_out_o
);
   logic [1:0]        rst_q;
   logic              rst_n_q;
   logic [SYNC_W-1:0] bus_s, bus_p_q;
   logic              cs_s, rd_s, wr_s, cck_s, gate_s;
   logic              cs_p, rd_p, wr_p, cck_p, gate_p;
   logic [1:0]        adr_s, adr_p;
   logic [7:0]        dat_s, dat_p;
   logic              tick, gate_rise, wr_evt, rd_evt, reading;
   logic              cw_self, cnt_wr, rb_hit;
   logic [15:0]       ce_q, ce_d, cr_q, cr_d, ld_val, dec1, dec2;
   logic [1:0]        fmt_q, fmt_d;
   logic [2:0]        mode_q, mode_d, m;
   logic              bcd_q, bcd_d, out_q, out_d, null_q, null_d;
   logic              load_q, load_d, trig_q, trig_d, whi_q, whi_d;
   logic              do_load, cnt_en, sq_term, sq_modes;
   logic [7:0]        data_q;
   itm_run_t          st_q, st_d;
   itm_rd_if          rd_bus ();

   // ----------------------------------------------------------------
   // reset release and pin sampling
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_q <= RST_SYNC;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n_q = rst_q[1];

   itm_pin_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n_q),
      .din_i   ({cs_n_i, rd_n_i, wr_n_i, addr_i, data_i, cnt_clk_i, gate_i}),
      .dout_o  (bus_s)
   );

   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         bus_p_q <= SYNC_RST;
      end else begin
         bus_p_q <= bus_s;
      end
   end
   assign {cs_s, rd_s, wr_s, adr_s, dat_s, cck_s, gate_s} = bus_s;
   assign {cs_p, rd_p, wr_p, adr_p, dat_p, cck_p, gate_p} = bus_p_q;

   // counter clocks act on the falling edge of the clock pin
   assign tick      = cck_p && !cck_s;
   assign gate_rise = gate_s && !gate_p;
   // a write takes effect at the trailing edge of the write strobe
   assign wr_evt    = wr_s && !wr_p && !cs_p;
   assign rd_evt    = rd_s && !rd_p && !cs_p && adr_p == CHAN;
   assign reading   = !cs_s && !rd_s && adr_s == CHAN;
   assign cw_self   = wr_evt && adr_p == ADDR_CTL && dat_p[7:6] == CHAN;
   assign cnt_wr    = wr_evt && adr_p == CHAN;
   assign rb_hit    = wr_evt && adr_p == ADDR_CTL && dat_p[7:6] == SC_RDBACK
                      && dat_p[RB_SEL_LO + int'(CHAN)];

   // ----------------------------------------------------------------
   // count arithmetic
   // ----------------------------------------------------------------
   function automatic logic [15:0] dec_cnt(input logic [15:0] v, input logic [1:0] step,
                                           input logic bcd);
      logic [15:0] r;
      logic [4:0]  t;
      logic [4:0]  b;
      r = v - {14'h0000, step};
      b = {3'h0, step};
      if (bcd) begin
         for (int i = 0; i < 4; i++) begin
            t = {1'b0, v[4*i +: 4]} - b;
            if (t[4]) begin
               t = t + 5'h0a;
               b = 5'h01;
            end else begin
               b = 5'h00;
            end
            r[4*i +: 4] = t[3:0];
         end
      end
      return r;
   endfunction : dec_cnt

   // modes 6 and 7 behave as 2 and 3
   assign m        = mode_q[1] ? {1'b0, mode_q[1:0]} : mode_q;
   assign sq_modes = m == MODE_2 || m == MODE_3;
   assign dec1     = dec_cnt(ce_q, STEP_ONE, bcd_q);
   assign dec2     = dec_cnt(ce_q, STEP_TWO, bcd_q);
   // odd square-wave counts run from N-1
   assign ld_val   = (m == MODE_3) ? {cr_q[15:1], 1'b0} : cr_q;
   // odd counts end the high half at 0, everything else at 2
   assign sq_term  = (out_q && cr_q[0]) ? ce_q == RST_CNT : ce_q == CNT_TWO;
   assign cnt_en   = (m == MODE_1 || m == MODE_5) ? 1'b1 : gate_s;
   assign do_load  = load_q || (trig_q && st_q != ST_IDLE && m != MODE_0
                     && m != MODE_4);

   // ----------------------------------------------------------------
   // counting element and control
   // ----------------------------------------------------------------
   always_comb begin
      logic done;
      done   = 1'b0;
      ce_d   = ce_q;
      cr_d   = cr_q;
      fmt_d  = fmt_q;
      mode_d = mode_q;
      bcd_d  = bcd_q;
      out_d  = out_q;
      null_d = null_q;
      load_d = load_q;
      trig_d = trig_q;
      whi_d  = whi_q;
      st_d   = st_q;
      if (tick) begin
         trig_d = 1'b0;
         if (do_load) begin
            // the loading clock does not decrement
            ce_d   = ld_val;
            load_d = 1'b0;
            null_d = 1'b0;
            st_d   = ST_RUN;
            if (m == MODE_1) begin
               out_d = 1'b0;
            end else if (m != MODE_0) begin
               out_d = 1'b1;
            end
         end else if (st_q == ST_RUN && cnt_en) begin
            case (m)
               MODE_2: begin
                  if (ce_q == CNT_TWO) begin
                     out_d = 1'b0;
                     ce_d  = CNT_ONE;
                  end else if (ce_q == CNT_ONE) begin
                     out_d  = 1'b1;
                     ce_d   = cr_q;
                     null_d = 1'b0;
                  end else begin
                     ce_d = dec1;
                  end
               end
               MODE_3: begin
                  if (sq_term) begin
                     out_d  = !out_q;
                     ce_d   = ld_val;
                     null_d = 1'b0;
                  end else begin
                     ce_d = dec2;
                  end
               end
               MODE_4, MODE_5: begin
                  ce_d = dec1;
                  if (!out_q) begin
                     out_d = 1'b1;
                     st_d  = ST_WAIT;
                  end else if (ce_q == CNT_ONE) begin
                     out_d = 1'b0;
                  end
               end
               default: begin
                  ce_d = dec1;
                  if (ce_q == CNT_ONE) begin
                     out_d = 1'b1;
                  end
               end
            endcase
         end
      end
      // the trigger is kept until a counter clock or a control word clears it; set wins over the clock
      if (gate_rise) begin
         trig_d = 1'b1;
      end
      if (sq_modes && !gate_s) begin
         out_d = 1'b1;
      end
      if (cw_self && dat_p[5:4] != RW_LATCH) begin
         fmt_d  = dat_p[5:4];
         mode_d = dat_p[3:1];
         bcd_d  = dat_p[0];
         ce_d   = RST_CNT;
         st_d   = ST_IDLE;
         load_d = 1'b0;
         trig_d = 1'b0;
         whi_d  = 1'b0;
         null_d = 1'b1;
         out_d  = dat_p[3:1] != MODE_0;
      end
      if (cnt_wr) begin
         case (fmt_q)
            RW_LSB: begin
               cr_d = {8'h00, dat_p};
               done = 1'b1;
            end
            RW_MSB: begin
               cr_d = {dat_p, 8'h00};
               done = 1'b1;
            end
            default: begin
               // write byte order is independent of read byte order
               whi_d = !whi_q;
               if (whi_q) begin
                  cr_d[15:8] = dat_p;
                  done       = 1'b1;
               end else begin
                  cr_d[7:0] = dat_p;
                  if (m == MODE_0) begin
                     st_d  = ST_WAIT;
                     out_d = 1'b0;
                  end
               end
            end
         endcase
         if (done) begin
            null_d = 1'b1;
            if (st_q == ST_IDLE) begin
               st_d = ST_WAIT;
            end
            // modes 1 and 5 wait for a trigger, running rate modes reload at terminal
            if (m == MODE_0 || m == MODE_4 || (sq_modes && st_q == ST_IDLE)) begin
               load_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ce_q   <= RST_CNT;
         cr_q   <= RST_CNT;
         fmt_q  <= RST_FMT;
         mode_q <= RST_MODE;
         bcd_q  <= 1'b0;
         out_q  <= 1'b1;
         null_q <= 1'b0;
         load_q <= 1'b0;
         trig_q <= 1'b0;
         whi_q  <= 1'b0;
         st_q   <= ST_IDLE;
      end else begin
         ce_q   <= ce_d;
         cr_q   <= cr_d;
         fmt_q  <= fmt_d;
         mode_q <= mode_d;
         bcd_q  <= bcd_d;
         out_q  <= out_d;
         null_q <= null_d;
         load_q <= load_d;
         trig_q <= trig_d;
         whi_q  <= whi_d;
         st_q   <= st_d;
      end
   end
   assign cnt_out_o = out_q;

   // ----------------------------------------------------------------
   // readout and data bus
   // ----------------------------------------------------------------
   assign rd_bus.ce_val    = ce_q;
   assign rd_bus.status    = {out_q, null_q, fmt_q, mode_q, bcd_q};
   assign rd_bus.fmt       = fmt_q;
   assign rd_bus.ctl_wr    = cw_self && dat_p[5:4] != RW_LATCH;
   assign rd_bus.latch_cnt = (cw_self && dat_p[5:4] == RW_LATCH)
                             || (rb_hit && !dat_p[RB_NO_CNT]);
   assign rd_bus.latch_st  = rb_hit && !dat_p[RB_NO_ST];
   assign rd_bus.rd_done   = rd_evt;

   itm_readout u_readout (
      .clk_i   (clk_sys_i),
      .rst_n_i (rst_n_q),
      .rd      (rd_bus)
   );

   always_ff @(posedge clk_sys_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         data_q <= 8'h00;
      end else if (reading) begin
         data_q <= rd_bus.rd_byte;
      end
   end
   assign data_o    = data_q;
   assign data_oe_o = reading;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   null_set_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      rd_bus.ctl_wr |=> null_q && st_q == ST_IDLE)
      else $error("control word did not set pending load");
   null_clear_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      tick && load_q && !wr_evt |=> !null_q && st_q == ST_RUN)
      else $error("load did not clear pending load");
   strobe_low_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      tick && m == MODE_4 && st_q == ST_RUN && gate_s && out_q && ce_q == CNT_ONE
      && !load_q && !wr_evt |=> !out_q)
      else $error("strobe missing at count zero");
   strobe_end_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      tick && m == MODE_5 && !out_q && !do_load && !wr_evt |=> out_q)
      else $error("strobe longer than one clock");
   gate_force_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      sq_modes && !gate_s && !wr_evt |=> out_q)
      else $error("gate low did not force output high");
   trig_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      gate_rise && !tick && !rd_bus.ctl_wr |=> trig_q)
      else $error("gate trigger lost");
   sq_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      tick && m == MODE_3 && st_q == ST_RUN && gate_s && !do_load && !sq_term
      && !bcd_q && !wr_evt |=> ce_q == $past(ce_q) - 16'h0002)
      else $error("square wave did not subtract two");
   load_nodec_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      tick && load_q && m == MODE_4 && !wr_evt |=> ce_q == $past(cr_q))
      else $error("loading clock decremented");
   gate_out_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_q)
      m == MODE_5 && gate_rise && !tick && !wr_evt |=> out_q == $past(out_q))
      else $error("gate changed strobe output directly");
endmodule : itm_timer

// file: verif/itm_host_model.sv
// host processor model driving the timer's bus pins
`timescale 1ns/1ps
module itm_host_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic            cs_n_o,
   output logic            rd_n_o,
   output logic            wr_n_o,
   output logic      [1:0] addr_o,
   output logic      [7:0] wdata_o
);
   initial {cs_n_o, rd_n_o, wr_n_o, addr_o, wdata_o} = {3'h7, 2'h0, 8'h00};
   // strobes held far beyond the pin synchroniser's minimum width
   task automatic cyc(input logic [1:0] a, input logic [7:0] d, input logic rd,
                      output logic [7:0] q);
      @(posedge clk_i) #1 {cs_n_o, rd_n_o, wr_n_o, addr_o, wdata_o} = {1'b0, !rd, rd, a, d};
      repeat (8) @(posedge clk_i);
      q = rdata_i;
      #1 {rd_n_o, wr_n_o} = 2'h3;
      repeat (4) @(posedge clk_i);
      #1 {cs_n_o, wdata_o} = {1'b1, ~d}; // released bus shows no stale byte
      repeat (4) @(posedge clk_i);
   endtask : cyc
endmodule : itm_host_model

// file: verif/tb.sv
// testbench of one timer channel: host model plus counter clock and gate
`timescale 1ns/1ps
module tb;
   import itm_pkg::*;
   logic       clk_sys = 1'b0, rst_n = 1'b0, cnt_clk = 1'b1, gate = 1'b1;
   logic       cs_n, rd_n, wr_n, oe, cnt_out;
   logic [1:0] addr;
   logic [7:0] wdata, rdata, q;
   int         n_mismatch = 0, check_count = 0, n_oe = 0;
   always #2.5 clk_sys = ~clk_sys;
   // cycles in which the channel drives the data bus
   always @(posedge clk_sys) if (oe === 1'b1) n_oe <= n_oe + 1;
   itm_host_model u_host (.clk_i(clk_sys), .rdata_i(rdata), .cs_n_o(cs_n), .rd_n_o(rd_n),
      .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
   itm_timer #(.CHAN(2'h0)) u_dut (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .cs_n_i(cs_n),
      .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(rdata),
      .data_oe_o(oe), .cnt_clk_i(cnt_clk), .gate_i(gate), .cnt_out_o(cnt_out));
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      int n0;
      n0 = n_oe;
      u_host.cyc(a, d, 1'b0, q);
      chk("write bus enable", 8'h00, {7'h0, n_oe != n0});
   endtask : wr
   task automatic rd();
      int n0;
      n0 = n_oe;
      u_host.cyc(2'h0, 8'h00, 1'b1, q);
      chk("read bus enable", 8'h01, {7'h0, n_oe > n0 && oe === 1'b0});
   endtask : rd
   // one counter-clock period of 8 sys cycles; the clock rests high between calls
   task automatic tick(input int n);
      repeat (n) begin
         @(posedge clk_sys) #1 cnt_clk = 1'b0;
         repeat (4) @(posedge clk_sys);
         #1 cnt_clk = 1'b1;
         repeat (3) @(posedge clk_sys);
      end
   endtask : tick
   task automatic trig();
      @(posedge clk_sys) #1 gate = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1 gate = 1'b1;
   endtask : trig
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_mode4();
      wr(ADDR_CTL, 8'h18);
      wr(2'h0, 8'h03);
      wr(ADDR_CTL, 8'he2);
      rd();
      chk("status before load", 8'hd8, q);
      for (int k = 1; k <= 5; k++) begin
         tick(1);
         chk("soft strobe", {7'h0, k != 4}, {7'h0, cnt_out});
      end
      wr(ADDR_CTL, 8'he2);
      rd();
      chk("status after load", 8'h98, q);
   endtask : t_mode4
   task automatic t_mode5();
      wr(ADDR_CTL, 8'h1a);
      wr(2'h0, 8'h02);
      tick(4);
      chk("no trigger", 8'h01, {7'h0, cnt_out});
      trig();
      tick(2);
      trig();
      for (int k = 1; k <= 4; k++) begin
         tick(1);
         chk("hard strobe", {7'h0, k != 3}, {7'h0, cnt_out});
      end
   endtask : t_mode5
   task automatic t_square(input logic [7:0] n, input int per, input int hi);
      int h;
      wr(ADDR_CTL, 8'h16);
      wr(2'h0, n);
      tick(1);
      h = 0;
      repeat (per) begin
         tick(1);
         h += (cnt_out === 1'b1);
      end
      chk("high ticks", 8'(hi), 8'(h));
      repeat (5) if (cnt_out === 1'b1) tick(1);
      chk("square low half", 8'h00, {7'h0, cnt_out});
      @(posedge clk_sys) #1 gate = 1'b0;
      repeat (6) @(posedge clk_sys);
      chk("gate low out", 8'h01, {7'h0, cnt_out});
      #1 gate = 1'b1;
   endtask : t_square
   task automatic t_latch();
      wr(ADDR_CTL, 8'h14);
      wr(2'h0, 8'h10);
      tick(3);
      wr(ADDR_CTL, 8'h00);
      tick(2);
      wr(ADDR_CTL, 8'h00);
      rd();
      chk("latched count", 8'h0e, q);
      rd(); // counter clock stopped, so an unlatched read is exact
      chk("direct count", 8'h0c, q);
      wr(ADDR_CTL, 8'hc2);
      rd();
      chk("status first", 8'h94, q);
      rd();
      chk("count second", 8'h0c, q);
   endtask : t_latch
   // two-byte format: reads and writes interleave, first byte leaves mode 4 counting alone
   task automatic t_twobyte();
      wr(ADDR_CTL, 8'h38);
      wr(2'h0, 8'h05);
      wr(2'h0, 8'h00);
      tick(1);
      rd();
      chk("live low byte", 8'h05, q);
      wr(2'h0, 8'h03);
      tick(1);
      rd();
      chk("live high byte", 8'h00, q);
      rd();
      chk("count after first byte", 8'h04, q);
      wr(2'h0, 8'h00);
      for (int k = 1; k <= 5; k++) begin
         tick(1);
         chk("two-byte strobe", {7'h0, k != 4}, {7'h0, cnt_out});
      end
   endtask : t_twobyte
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : test_done
   initial begin
      repeat (12) @(posedge clk_sys);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("reset out", 8'h01, {7'h0, cnt_out});
      t_mode4();
      t_mode5();
      t_square(8'h04, 8, 4);
      t_square(8'h05, 10, 6);
      t_latch();
      t_twobyte();
      test_done();
   end
endmodule : tb
